/* hdl/pcsfc_config.v */
// Coding-sublayer and interface-mode configuration bank with AXI4-Lite access.
// Assumes straps, the force-link input and the reference clock are asynchronous
// pins; the descrambler lock-refresh pulse comes from logic on aclk.
//
// Functional notes
// RULE1: Timeout 2 ms if extended, else 722 us.
// RULE2: Fiber enable loads from strap, then software-writable.
// RULE3: Software issues soft reset after changing fiber mode.
// RULE4: Forced fast link is register bit OR input.
// RULE5: Reserved bit 4 ignores writes, reads zero.
// RULE6: Far-end fault enable loads from fiber strap.
// RULE7: NRZI bypass bit skips NRZI coding, default off.
// RULE8: Scrambler skip loads from fiber strap.
// RULE9: Descrambler skip loads from fiber strap.
// RULE10: Master uses 25 MHz ref, else 50 MHz.
// RULE11: Software changes master selection by strap only; the code also lets writes to interface bit 14 change it.
// RULE12: Software writes zero to interface reserved bit 15.
// RULE13: Straps captured after reset release, then writable.
`include "pcsfc_defines.vh"
`default_nettype none

module pcsfc_config #(
  parameter DESC_LONG_CYC = `PCSFC_DESC_LONG_NS / `PCSFC_CLK_NS,
  parameter DESC_SHORT_CYC = `PCSFC_DESC_SHORT_NS / `PCSFC_CLK_NS
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire fiber_strap,
  input wire rmii_master_strap,
  input wire external_force_fast_link,
  input wire ref_clk_in,
  input wire rx_lock_refresh,
  output wire descrambler_timeout_extend,
  output wire fiber_mode_enable,
  output wire force_fast_link,
  output wire far_end_fault_enable,
  output wire nrzi_bypass,
  output wire tx_scrambler_skip,
  output wire rx_descrambler_skip,
  output wire rmii_master,
  output wire rx_sync_lost
);

  // Register select codes
  localparam [1:0] SEL_NONE = 2'h0;
  localparam [1:0] SEL_PCS = 2'h1;
  localparam [1:0] SEL_IFM = 2'h2;
  localparam [1:0] SEL_STAT = 2'h3;
  // Decode a byte address into a register select; low two bits ignored
  function [1:0] reg_sel;
    input [31:0] addr;
    begin
      if (addr[31:2] == {22'h0, `PCSFC_IDX_PCS_CONFIG}) begin
        reg_sel = SEL_PCS;
      end else if (addr[31:2] == {22'h0, `PCSFC_IDX_IFMODE}) begin
        reg_sel = SEL_IFM;
      end else if (addr[31:2] == {22'h0, `PCSFC_IDX_STATUS}) begin
        reg_sel = SEL_STAT;
      end else begin
        reg_sel = SEL_NONE;
      end
    end
  endfunction
  // Merge write data into an 8-bit lane under its strobe
  function [7:0] lane_merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input strobe;
    begin
      lane_merge = strobe ? new_val : old_val;
    end
  endfunction
  // Synchronised pins; a pin change counts once stages two and three agree
  wire fiber_strap_s;
  wire master_strap_s;
  wire force_in_s;
  wire ref_clk_s;
  pcsfc_sync3 u_sync_fiber (.aclk(aclk), .aresetn(aresetn), .pin_in(fiber_strap), .level_out(fiber_strap_s));
  pcsfc_sync3 u_sync_master (.aclk(aclk), .aresetn(aresetn), .pin_in(rmii_master_strap),
    .level_out(master_strap_s));
  pcsfc_sync3 u_sync_force (.aclk(aclk), .aresetn(aresetn), .pin_in(external_force_fast_link),
    .level_out(force_in_s));
  pcsfc_sync3 u_sync_ref (.aclk(aclk), .aresetn(aresetn), .pin_in(ref_clk_in), .level_out(ref_clk_s));

  // Bus state
  reg aw_hold_ff;
  reg [31:0] aw_addr_ff;
  reg w_hold_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg awready_ff;
  reg wready_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg arready_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  // Configuration state
  reg [7:0] pcs_ff;
  reg if_rsvd15_ff;
  reg master_ff;
  reg force_link_ff;
  reg [2:0] settle_ff;
  reg [16:0] desc_cnt_ff;
  reg lock_ff;
  reg sync_lost_ff;
  reg ref_prev_ff;
  reg [7:0] ref_gap_ff;
  reg [7:0] ref_period_ff;
  reg ref_active_ff;
  reg nxt_aw_hold;
  reg nxt_w_hold;
  reg nxt_bvalid;
  reg nxt_rvalid;
  reg [31:0] rd_word;
  reg rd_ok;
  wire aw_take = s_axi_awvalid && awready_ff;
  wire w_take = s_axi_wvalid && wready_ff;
  wire ar_take = s_axi_arvalid && arready_ff;
  wire wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
  wire [1:0] wr_sel = reg_sel(aw_addr_ff);
  wire [1:0] rd_sel = reg_sel(s_axi_araddr);
  wire strap_load = (settle_ff == 3'h1);
  wire [16:0] desc_limit = pcs_ff[`PCSFC_B_DESC_EXT] ? DESC_LONG_CYC[16:0] : DESC_SHORT_CYC[16:0];
  wire ref_rise = ref_clk_s && !ref_prev_ff;
  // Handshake next state: a held address or data waits for its partner
  always @* begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold = w_hold_ff;
    nxt_bvalid = bvalid_ff;
    nxt_rvalid = rvalid_ff;
    if (aw_take) begin
      nxt_aw_hold = 1'b1;
    end
    if (w_take) begin
      nxt_w_hold = 1'b1;
    end
    if (wr_go) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold = 1'b0;
      nxt_bvalid = 1'b1;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_rvalid = 1'b1;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end
  // Write channel registers; one write in flight at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 32'h0;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `PCSFC_RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= !nxt_aw_hold && !nxt_bvalid;
      wready_ff <= !nxt_w_hold && !nxt_bvalid;
      if (aw_take) begin
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        bresp_ff <= (wr_sel == SEL_PCS || wr_sel == SEL_IFM) ? `PCSFC_RESP_OKAY : `PCSFC_RESP_SLVERR;
      end
    end
  end
  // Read mux; status register is read-only, unmapped reads give zero
  always @* begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    case (rd_sel)
      SEL_PCS: begin
        rd_word[7:0] = pcs_ff & ~(8'h1 << `PCSFC_B_RSVD4); // RULE5
      end
      SEL_IFM: begin
        rd_word[`PCSFC_B_IF_RSVD15] = if_rsvd15_ff;
        rd_word[`PCSFC_B_RMII_MASTER] = master_ff;
      end
      SEL_STAT: begin
        rd_word[0] = lock_ff;
        rd_word[1] = ref_active_ff;
        rd_word[2] = force_link_ff;
        rd_word[15:8] = ref_period_ff;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end
  // Read channel: data is captured when the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `PCSFC_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= !nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_ok ? `PCSFC_RESP_OKAY : `PCSFC_RESP_SLVERR;
      end
    end
  end
  // Configuration bits; the strap load wins over a write in the same cycle,
  // so a write landing in the strap-load cycle is dropped whole, though it still answers OKAY
  always @(posedge aclk) begin
    if (!aresetn) begin
      pcs_ff <= {`PCSFC_RST_DESC_EXT, 1'b0, `PCSFC_RST_FORCE_LINK, 1'b0, 1'b0, `PCSFC_RST_NRZI, 1'b0, 1'b0};
      if_rsvd15_ff <= `PCSFC_RST_IF_RSVD15;
      master_ff <= 1'b0;
      settle_ff <= `PCSFC_STRAP_SETTLE;
    end else begin
      if (settle_ff != 3'h0) begin
        settle_ff <= settle_ff - 3'h1;
      end
      if (strap_load) begin
        pcs_ff[`PCSFC_B_FIBER] <= fiber_strap_s; // RULE2 RULE13
        pcs_ff[`PCSFC_B_FEFI] <= fiber_strap_s; // RULE6
        pcs_ff[`PCSFC_B_SCRAM] <= fiber_strap_s; // RULE8
        pcs_ff[`PCSFC_B_DESCRAM] <= fiber_strap_s; // RULE9
        master_ff <= master_strap_s; // RULE10 RULE13
      end else if (wr_go && wr_sel == SEL_PCS) begin
        pcs_ff <= lane_merge(pcs_ff, w_data_ff[7:0], w_strb_ff[0]) & ~(8'h1 << `PCSFC_B_RSVD4); // RULE5
      end else if (wr_go && wr_sel == SEL_IFM && w_strb_ff[1]) begin
        if_rsvd15_ff <= w_data_ff[`PCSFC_B_IF_RSVD15];
        master_ff <= w_data_ff[`PCSFC_B_RMII_MASTER]; // RULE10
      end
    end
  end

  // Forced link follows either source; registered so the output is a flop
  always @(posedge aclk) begin
    if (!aresetn) begin
      force_link_ff <= 1'b0;
    end else begin
      force_link_ff <= pcs_ff[`PCSFC_B_FORCE_LINK] | force_in_s; // RULE4
    end
  end

  // Descrambler lock timer; the long limit tolerates jumbo frames
  always @(posedge aclk) begin
    if (!aresetn) begin
      desc_cnt_ff <= 17'h0;
      lock_ff <= 1'b0;
      sync_lost_ff <= 1'b0;
    end else begin
      sync_lost_ff <= 1'b0;
      if (rx_lock_refresh) begin
        desc_cnt_ff <= 17'h0;
        lock_ff <= 1'b1;
      end else if (lock_ff) begin
        if (desc_cnt_ff >= desc_limit - 17'h1) begin // RULE1
          desc_cnt_ff <= 17'h0;
          lock_ff <= 1'b0;
          sync_lost_ff <= 1'b1;
        end else begin
          desc_cnt_ff <= desc_cnt_ff + 17'h1;
        end
      end
    end
  end

  // Reference clock monitor: period in aclk cycles, and activity flag.
  // At 40 MHz only a slow bench reference can be measured exactly.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev_ff <= 1'b0;
      ref_gap_ff <= 8'h0;
      ref_period_ff <= 8'h0;
      ref_active_ff <= 1'b0;
    end else begin
      ref_prev_ff <= ref_clk_s;
      if (ref_rise) begin
        ref_period_ff <= ref_gap_ff + 8'h1;
        ref_gap_ff <= 8'h0;
        ref_active_ff <= 1'b1;
      end else if (ref_gap_ff == `PCSFC_REF_STALL) begin
        ref_active_ff <= 1'b0;
      end else begin
        ref_gap_ff <= ref_gap_ff + 8'h1;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign descrambler_timeout_extend = pcs_ff[`PCSFC_B_DESC_EXT]; // RULE1
  assign fiber_mode_enable = pcs_ff[`PCSFC_B_FIBER];
  assign force_fast_link = force_link_ff;
  assign far_end_fault_enable = pcs_ff[`PCSFC_B_FEFI];
  assign nrzi_bypass = pcs_ff[`PCSFC_B_NRZI]; // RULE7
  assign tx_scrambler_skip = pcs_ff[`PCSFC_B_SCRAM];
  assign rx_descrambler_skip = pcs_ff[`PCSFC_B_DESCRAM];
  assign rmii_master = master_ff;
  assign rx_sync_lost = sync_lost_ff;

endmodule // pcsfc_config

`default_nettype wire

/* hdl/pcsfc_defines.vh */
// Constants for the coding-sublayer and interface-mode configuration bank.
// Assumes a 40 MHz aclk; included by every file of the block except the synchroniser and the reference source.
`ifndef PCSFC_DEFINES_VH
`define PCSFC_DEFINES_VH

// Printed register indices; byte address is four times the index
`define PCSFC_IDX_PCS_CONFIG 8'h16
`define PCSFC_IDX_IFMODE 8'h17
`define PCSFC_IDX_STATUS 8'h18

// Coding-sublayer register field positions
`define PCSFC_B_DESC_EXT 7
`define PCSFC_B_FIBER 6
`define PCSFC_B_FORCE_LINK 5
`define PCSFC_B_RSVD4 4
`define PCSFC_B_FEFI 3
`define PCSFC_B_NRZI 2
`define PCSFC_B_SCRAM 1
`define PCSFC_B_DESCRAM 0

// Interface-mode register field positions
`define PCSFC_B_IF_RSVD15 15
`define PCSFC_B_RMII_MASTER 14

// Reset values of the non-strap bits
`define PCSFC_RST_DESC_EXT 1'b0
`define PCSFC_RST_FORCE_LINK 1'b0
`define PCSFC_RST_NRZI 1'b0
`define PCSFC_RST_IF_RSVD15 1'b0

// Timing: clock period and descrambler timeouts in ns
`define PCSFC_CLK_NS 25
`define PCSFC_DESC_LONG_NS 2000000
`define PCSFC_DESC_SHORT_NS 722000

// Cycles after reset release before straps are loaded
`define PCSFC_STRAP_SETTLE 3'h5
// Aclk cycles without a reference edge before it counts as stopped
`define PCSFC_REF_STALL 8'h40

// AXI responses
`define PCSFC_RESP_OKAY 2'h0
`define PCSFC_RESP_SLVERR 2'h2

`endif

/* hdl/pcsfc_sync3.v */
// Three-stage synchroniser for a pin or foreign-clock level.
// Assumes a level that is stable for several aclk cycles per change.
`default_nettype none

module pcsfc_sync3 (
  input wire aclk,
  input wire aresetn,
  input wire pin_in,
  output wire level_out
);

  reg stage1_ff;
  reg stage2_ff;
  reg stage3_ff;
  reg level_ff;

  // First stage feeds only the second; change accepted when 2 and 3 agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
      stage3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      if (stage2_ff == stage3_ff) begin
        level_ff <= stage3_ff;
      end
    end
  end

  assign level_out = level_ff;

endmodule // pcsfc_sync3

`default_nettype wire

/* testbench/pcsfc_config_props.sv */
// Checker for the configuration bank ports.
// Assumes a bind onto pcsfc_config, one aclk domain.
`include "pcsfc_defines.vh"
`default_nettype none
module pcsfc_config_props #(
  parameter int DESC_LONG_CYC = 40,
  parameter int DESC_SHORT_CYC = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic fiber_strap,
  input wire logic rmii_master_strap,
  input wire logic external_force_fast_link,
  input wire logic rx_lock_refresh,
  input wire logic descrambler_timeout_extend,
  input wire logic fiber_mode_enable,
  input wire logic force_fast_link,
  input wire logic far_end_fault_enable,
  input wire logic nrzi_bypass,
  input wire logic tx_scrambler_skip,
  input wire logic rx_descrambler_skip,
  input wire logic rmii_master,
  input wire logic rx_sync_lost
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] wa_ff;
  logic [31:0] ra_ff;
  logic [16:0] cnt_ff;
  logic [3:0] rel_ff;
  // Seventeen bits so the full-length timeouts fit as well
  wire [16:0] lim = descrambler_timeout_extend ? 17'(DESC_LONG_CYC) : 17'(DESC_SHORT_CYC);
  // Last addresses, cycles since refresh (saturating), cycles since release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa_ff <= 32'h0;
      ra_ff <= 32'h0;
      cnt_ff <= 17'h1FFFF;
      rel_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
      cnt_ff <= rx_lock_refresh ? 17'h0 : cnt_ff + {16'h0, cnt_ff != 17'h1FFFF};
      if (rel_ff != 4'hF) rel_ff <= rel_ff + 4'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_bvalid; s_wr |-> ##2 s_axi_bvalid; endproperty
  a_bvalid: assert property (p_bvalid) else $error("write answer off time");
  property p_rvalid; s_rd |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer off time");
  property p_bresp;
    s_axi_bvalid |-> s_axi_bresp == ((wa_ff == 32'h58 || wa_ff == 32'h5C) ? `PCSFC_RESP_OKAY : `PCSFC_RESP_SLVERR);
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response code wrong");
  property p_rsvd4; s_axi_rvalid && ra_ff == 32'h58 |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[4]; endproperty
  a_rsvd4: assert property (p_rsvd4) else $error("reserved bits read nonzero");
  property p_mirror;
    s_axi_rvalid && ra_ff == 32'h58 |-> s_axi_rdata[7:6] == {descrambler_timeout_extend, fiber_mode_enable}
      && s_axi_rdata[3:0] == {far_end_fault_enable, nrzi_bypass, tx_scrambler_skip, rx_descrambler_skip};
  endproperty
  a_mirror: assert property (p_mirror) else $error("read value differs from outputs");
  property p_master; s_axi_rvalid && ra_ff == 32'h5C |-> s_axi_rdata[14] == rmii_master; endproperty
  a_master: assert property (p_master) else $error("master bit differs from output");
  property p_force; external_force_fast_link [*8] |-> force_fast_link; endproperty
  a_force: assert property (p_force) else $error("pin did not force link");
  property p_strap;
    rel_ff == 4'hA |-> fiber_mode_enable == fiber_strap && far_end_fault_enable == fiber_strap
      && tx_scrambler_skip == fiber_strap && rx_descrambler_skip == fiber_strap
      && rmii_master == rmii_master_strap && !nrzi_bypass && !descrambler_timeout_extend;
  endproperty
  a_strap: assert property (p_strap) else $error("strap defaults not loaded");
  property p_lost; rx_sync_lost |-> cnt_ff == lim; endproperty
  a_lost: assert property (p_lost) else $error("sync loss at wrong time");
endmodule // pcsfc_config_props
bind pcsfc_config pcsfc_config_props #(.DESC_LONG_CYC(DESC_LONG_CYC), .DESC_SHORT_CYC(DESC_SHORT_CYC))
  u_pcsfc_config_props (.*);
`default_nettype wire

/* testbench/pcsfc_ref_src.sv */
// Reference clock source on the far side of the block.
// Assumes the bench enables it; parked low while stopped.
`default_nettype none
module pcsfc_ref_src (
  input wire logic run,
  output logic ref_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // 200 ns period while running; a stopped source shows a quiet line
  initial begin
    ref_clk = 1'b0;
    forever #100 ref_clk = run ? ~ref_clk : 1'b0;
  end
endmodule // pcsfc_ref_src
`default_nettype wire

/* testbench/pcs_fiber_and_rmii_clock_config_test.sv */
// Self-checking bench for the configuration bank.
// Assumes the design, its defines header, checker and reference source.
`include "pcsfc_defines.vh"
`default_nettype none
module pcs_fiber_and_rmii_clock_config_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LC = 40;
  localparam int SC = 20;
  localparam logic [1:0] OK = `PCSFC_RESP_OKAY;
  localparam logic [1:0] ER = `PCSFC_RESP_SLVERR;
  logic aclk = 0, aresetn = 0, ref_run = 0, rx_lock_refresh = 0, external_force_fast_link = 0;
  logic fiber_strap = 1, rmii_master_strap = 1;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic descrambler_timeout_extend, fiber_mode_enable, force_fast_link, far_end_fault_enable;
  logic nrzi_bypass, tx_scrambler_skip, rx_descrambler_skip, rmii_master, rx_sync_lost;
  wire ref_clk_in;
  int fails = 0, cmp_count = 0;
  pcsfc_config #(.DESC_LONG_CYC(LC), .DESC_SHORT_CYC(SC)) u_pcsfc_config (.*);
  pcsfc_ref_src u_pcsfc_ref_src (.run(ref_run), .ref_clk(ref_clk_in));
  // Clock and hang guard
  initial forever #12.5 aclk = ~aclk;
  initial begin
    #200us;
    fails++;
    wrap_up;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] outs();
    return {24'h0, descrambler_timeout_extend, fiber_mode_enable, force_fast_link, 1'b0,
      far_end_fault_enable, nrzi_bypass, tx_scrambler_skip, rx_descrambler_skip};
  endfunction
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (!w && s_axi_wready) s_axi_wvalid <= 1'b0;
      aw |= s_axi_awready;
      w |= s_axi_wready;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rdc(input logic [31:0] a, ed, input logic [1:0] er, input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, s_axi_rdata & m);
    chk("rresp", er, s_axi_rresp);
  endtask
  task automatic rst(input logic fs, ms);
    @(posedge aclk);
    fiber_strap <= fs;
    rmii_master_strap <= ms;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
  endtask
  task automatic t_straps;
    rst(1'b1, 1'b1);
    chk("outs", 32'h4B, outs());
    rdc(32'h58, 32'h4B, OK);
    rdc(32'h5C, 32'h4000, OK);
    rst(1'b0, 1'b0);
    chk("outs", 32'h0, outs());
    chk("master", 32'h0, rmii_master);
    wr(32'h5C, 32'h4000, 4'h2, OK);
    chk("master", 32'h1, rmii_master);
  endtask
  task automatic t_fields;
    logic [31:0] e;
    for (int i = 0; i < 8; i++) begin
      e = (i == 4) ? 32'h0 : 32'h1 << i;
      wr(32'h58, 32'h1 << i, 4'h1, OK);
      rdc(32'h58, e, OK);
      chk("outs", e, outs());
    end
    wr(32'h58, 32'hFFFF, 4'h3, OK);
    wr(32'h58, 32'h0, 4'hE, OK);
    rdc(32'h58, 32'hEF, OK);
    wr(32'h58, 32'h0, 4'h1, OK);
    // Soft reset sits outside this bank; a full reset follows the fiber changes
    rst(1'b0, 1'b0);
  endtask
  task automatic t_force;
    @(posedge aclk) external_force_fast_link <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("force", 32'h1, force_fast_link);
    rdc(32'h60, 32'h4, OK, 32'h4);
    @(posedge aclk) external_force_fast_link <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("force", 32'h0, force_fast_link);
  endtask
  task automatic t_errs;
    wr(32'h64, 32'hFF, 4'hF, ER);
    wr(32'h60, 32'hFF, 4'hF, ER);
    wr(32'h16, 32'hFF, 4'hF, ER);
    rdc(32'h64, 32'h0, ER);
    rdc(32'h58, 32'h0, OK);
  endtask
  task automatic t_timeout;
    int n;
    int lim;
    for (int x = 0; x < 2; x++) begin
      lim = x ? LC : SC;
      wr(32'h58, x << 7, 4'h1, OK);
      @(posedge aclk) rx_lock_refresh <= 1'b1;
      @(posedge aclk) rx_lock_refresh <= 1'b0;
      n = 0;
      while (rx_sync_lost !== 1'b1 && n < 200) begin
        @(posedge aclk);
        n++;
      end
      // The loop sees the pulse one edge after the edge that launches it
      chk("lost_cycles", lim + 1, n);
      rdc(32'h60, 32'h0, OK, 32'h1);
    end
  endtask
  task automatic t_ref;
    @(posedge aclk) ref_run <= 1'b1;
    repeat (40) @(posedge aclk);
    // 200 ns reference over a 25 ns clock gives a period count of 8
    rdc(32'h60, 32'h0802, OK, 32'hFF02);
    @(posedge aclk) ref_run <= 1'b0;
    repeat (90) @(posedge aclk);
    rdc(32'h60, 32'h0, OK, 32'h2);
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    t_straps;
    t_fields;
    t_force;
    t_errs;
    t_timeout;
    t_ref;
    wrap_up;
  end
endmodule // pcs_fiber_and_rmii_clock_config_test
`default_nettype wire
